/* hw/memory_map_pkg.sv */
// constants of the data memory map and interrupt register bank
package memory_map_pkg;
  localparam int ROM_DEPTH = 4096;
  localparam int ROM_WIDTH = 12;
  localparam int PAGE_COUNT = 16;
  localparam int PAGE_STEPS = 256;
  localparam logic [3:0] RESET_PAGE = 4'h1;
  localparam logic [7:0] RESET_STEP = 8'h00;
  localparam logic [7:0] VECTOR_FIRST = 8'h02;
  localparam logic [7:0] VECTOR_LAST = 8'h0C;
  localparam logic [11:0] RAM_FIRST = 12'h000;
  localparam logic [11:0] RAM_LAST = 12'h1FF;
  localparam logic [11:0] MEMREG_LAST = 12'h00F;
  localparam logic [11:0] DISP_LO_FIRST = 12'hE00;
  localparam logic [11:0] DISP_LO_LAST = 12'hE4F;
  localparam logic [11:0] DISP_HI_FIRST = 12'hE80;
  localparam logic [11:0] DISP_HI_LAST = 12'hECF;
  localparam int DISP_WORDS = 160;
  localparam int STACK_WORDS_PER_CALL = 3;
  localparam logic [11:0] CLOCK_TIMER_IRQ_FLAGS = 12'hF00;
  localparam logic [11:0] STOPWATCH_IRQ_FLAGS = 12'hF01;
  localparam logic [11:0] PROG_TIMER_IRQ_FLAG = 12'hF02;
  localparam logic [11:0] INPUT_PORT_IRQ_FLAG = 12'hF04;
  localparam logic [11:0] CLOCK_TIMER_IRQ_MASKS = 12'hF10;
  localparam logic [11:0] STOPWATCH_IRQ_MASKS = 12'hF11;
  localparam logic [11:0] PROG_TIMER_IRQ_MASK = 12'hF12;
  localparam logic [11:0] INPUT_PORT_IRQ_MASKS = 12'hF14;
  localparam logic [11:0] CLOCK_DIVIDER_LOW_NIBBLE = 12'hF20;
  localparam logic [11:0] PROG_COUNTER_REG = 12'hF30;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [3:0] SW_WRITABLE = 4'h3;
  localparam logic [3:0] PT_WRITABLE = 4'h1;
endpackage
`default_nettype wire

/* hw/nibble_ram.sv */
// nibble-wide storage with one write and one read port
`timescale 1ns/100ps
`default_nettype none
module nibble_ram #(
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [3:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [3:0] rdata
);
  logic [3:0] mem [DEPTH];
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end
  assign rdata = mem[raddr];
endmodule // nibble_ram
`default_nettype wire

/* hw/memory_map_irq_regs.sv */
// data memory map, interrupt flag and mask registers over apb
// Function
// - program memory holds 4096 words of 12 bits
// - program address is 16 pages of 256 steps
// - after reset fetching starts at page 1 step 00H
// - interrupt vectors sit at page 1 steps 02H to 0CH
// - general ram is 512 nibbles at 000H to 1FFH
// - display memory is 160 nibbles at E00H-E4FH and E80H-ECFH
// - each call or interrupt pushes 3 nibbles onto stack in ram
// - addresses 000H to 00FH also reached through the register pointer
// - factor flags clear right after being read
// - unimplemented io bits read as zero
// - CLOCK_TIMER_IRQ_FLAGS holds clock timer flags 1, 2, 8, 32 Hz
// - STOPWATCH_IRQ_FLAGS holds stopwatch flags 1 Hz and 10 Hz
// - PROG_TIMER_IRQ_FLAG bit 0 holds programmable timer flag
// - INPUT_PORT_IRQ_FLAG bit 0 holds one flag shared by four input lines
// - CLOCK_TIMER_IRQ_MASKS holds clock timer masks, reset to zero
// - STOPWATCH_IRQ_MASKS writable stopwatch masks in bits 1 and 0
// - PROG_TIMER_IRQ_MASK writable programmable timer mask in bit 0
// - INPUT_PORT_IRQ_MASKS holds four input line masks
// - CLOCK_DIVIDER_LOW_NIBBLE bits 3 and 2 show 16 Hz and 32 Hz stages
// - CLOCK_DIVIDER_LOW_NIBBLE bits 1 and 0 show 64 Hz and 128 Hz stages
`timescale 1ns/100ps
`default_nettype none
module memory_map_irq_regs #(
  parameter int RAM_DEPTH = 512,
  parameter int DISP_DEPTH = 160
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] ct_events,
  input wire logic [1:0] sw_events,
  input wire logic pt_event,
  input wire logic [3:0] input_port_lines,
  input wire logic [3:0] divider_stages,
  input wire logic push_stack,
  input wire logic [11:0] return_addr,
  input wire logic [3:0] memreg_pointer,
  output logic [3:0] memreg_data,
  output logic irq_request,
  output logic [11:0] fetch_addr
);
  typedef struct packed {
    logic [3:0] ct_flags;
    logic [1:0] sw_flags;
    logic pt_flag;
    logic port_flag;
    logic [3:0] ct_mask;
    logic [1:0] sw_mask;
    logic pt_mask;
    logic [3:0] port_mask;
    logic [3:0] div_nibble;
    logic [3:0] port_prev;
    logic [11:0] pc;
    logic [8:0] sp;
    logic [1:0] push_cnt;
    logic [31:0] rdata;
    logic err;
  } state_type;

  state_type cur_ff;
  state_type nxt_cur;

  // apb address is a byte address; each nibble register takes a word
  function automatic logic [11:0] word_of(input logic [31:0] a);
    word_of = a[13:2];
  endfunction

  function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo,
                                    input logic [11:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  logic [11:0] waddr_word;
  logic setup_ok;
  logic rd_en;
  logic wr_en;
  logic ram_hit;
  logic disp_hit;
  logic io_hit;
  logic [3:0] ram_rdata;
  logic [3:0] disp_rdata;
  logic [3:0] io_rdata;
  logic ram_we;
  logic [8:0] ram_waddr;
  logic [3:0] ram_wdata;
  logic [7:0] disp_idx;
  logic disp_we;
  logic [3:0] disp_mem [DISP_DEPTH];
  logic [3:0] port_rise;

  assign waddr_word = word_of(paddr);
  assign setup_ok = psel && !penable;
  assign rd_en = setup_ok && !pwrite;
  assign wr_en = setup_ok && pwrite && pstrb[0];
  assign ram_hit = in_range(waddr_word, memory_map_pkg::RAM_FIRST,
                            memory_map_pkg::RAM_LAST);
  assign disp_hit = in_range(waddr_word, memory_map_pkg::DISP_LO_FIRST,
                             memory_map_pkg::DISP_LO_LAST) ||
                    in_range(waddr_word, memory_map_pkg::DISP_HI_FIRST,
                             memory_map_pkg::DISP_HI_LAST);
  // display halves packed into one 160 word store
  assign disp_idx = waddr_word[7] ? 8'(waddr_word[6:0]) + 8'h50 : waddr_word[7:0];

  // stack pushes win the ram write port over the bus
  always_comb
  begin
    ram_we = 1'b0;
    ram_waddr = waddr_word[8:0];
    ram_wdata = pwdata[3:0];
    if (cur_ff.push_cnt != 2'h0)
    begin
      ram_we = 1'b1;
      ram_waddr = cur_ff.sp;
      ram_wdata = return_addr[4*(cur_ff.push_cnt-2'h1) +: 4];
    end
    else if (wr_en && ram_hit)
    begin
      ram_we = 1'b1;
    end
  end

  nibble_ram #(
    .DEPTH(RAM_DEPTH),
    .AW(9)
  ) u_ram (
    .pclk(pclk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(waddr_word[8:0]),
    .rdata(ram_rdata)
  );

  // memory registers read through the pointer
  assign memreg_data = u_ram.mem[memreg_pointer];

  assign disp_we = wr_en && disp_hit;
  always_ff @(posedge pclk)
  begin
    if (disp_we)
    begin
      disp_mem[disp_idx] <= pwdata[3:0];
    end
  end
  assign disp_rdata = disp_mem[disp_idx];

  // io read mux, unused bits zero
  always_comb
  begin
    io_hit = 1'b1;
    io_rdata = 4'h0;
    case (waddr_word)
      memory_map_pkg::CLOCK_TIMER_IRQ_FLAGS: io_rdata = cur_ff.ct_flags;
      memory_map_pkg::STOPWATCH_IRQ_FLAGS: io_rdata = {2'h0, cur_ff.sw_flags};
      memory_map_pkg::PROG_TIMER_IRQ_FLAG: io_rdata = {3'h0, cur_ff.pt_flag};
      memory_map_pkg::INPUT_PORT_IRQ_FLAG: io_rdata = {3'h0, cur_ff.port_flag};
      memory_map_pkg::CLOCK_TIMER_IRQ_MASKS: io_rdata = cur_ff.ct_mask;
      memory_map_pkg::STOPWATCH_IRQ_MASKS: io_rdata = {2'h0, cur_ff.sw_mask};
      memory_map_pkg::PROG_TIMER_IRQ_MASK: io_rdata = {3'h0, cur_ff.pt_mask};
      memory_map_pkg::INPUT_PORT_IRQ_MASKS: io_rdata = cur_ff.port_mask;
      memory_map_pkg::CLOCK_DIVIDER_LOW_NIBBLE: io_rdata = cur_ff.div_nibble;
      default: io_hit = 1'b0;
    endcase
  end

  assign port_rise = input_port_lines & ~cur_ff.port_prev;

  always_comb
  begin
    logic rd_io;
    rd_io = rd_en && io_hit;
    nxt_cur = cur_ff;
    nxt_cur.port_prev = input_port_lines;
    nxt_cur.div_nibble = divider_stages;
    // read clears, a same-cycle event wins
    if (rd_io && waddr_word == memory_map_pkg::CLOCK_TIMER_IRQ_FLAGS)
    begin
      nxt_cur.ct_flags = memory_map_pkg::NIBBLE_RESET;
    end
    if (rd_io && waddr_word == memory_map_pkg::STOPWATCH_IRQ_FLAGS)
    begin
      nxt_cur.sw_flags = 2'h0;
    end
    if (rd_io && waddr_word == memory_map_pkg::PROG_TIMER_IRQ_FLAG)
    begin
      nxt_cur.pt_flag = 1'b0;
    end
    if (rd_io && waddr_word == memory_map_pkg::INPUT_PORT_IRQ_FLAG)
    begin
      nxt_cur.port_flag = 1'b0;
    end
    nxt_cur.ct_flags = nxt_cur.ct_flags | ct_events;
    nxt_cur.sw_flags = nxt_cur.sw_flags | sw_events;
    nxt_cur.pt_flag = nxt_cur.pt_flag | pt_event;
    nxt_cur.port_flag = nxt_cur.port_flag | (|(port_rise & cur_ff.port_mask));
    if (wr_en)
    begin
      case (waddr_word)
        memory_map_pkg::CLOCK_TIMER_IRQ_MASKS: nxt_cur.ct_mask = pwdata[3:0];
        memory_map_pkg::STOPWATCH_IRQ_MASKS:
          nxt_cur.sw_mask = pwdata[1:0] & memory_map_pkg::SW_WRITABLE[1:0];
        memory_map_pkg::PROG_TIMER_IRQ_MASK:
          nxt_cur.pt_mask = pwdata[0] & memory_map_pkg::PT_WRITABLE[0];
        memory_map_pkg::INPUT_PORT_IRQ_MASKS: nxt_cur.port_mask = pwdata[3:0];
        default: nxt_cur.err = cur_ff.err;
      endcase
    end
    // read data captured in setup, held through access
    if (setup_ok)
    begin
      nxt_cur.err = !(ram_hit || disp_hit || io_hit);
      if (ram_hit)
      begin
        nxt_cur.rdata = {28'h0, ram_rdata};
      end
      else if (disp_hit)
      begin
        nxt_cur.rdata = {28'h0, disp_rdata};
      end
      else if (io_hit)
      begin
        nxt_cur.rdata = {28'h0, io_rdata};
      end
      else if (waddr_word == memory_map_pkg::PROG_COUNTER_REG)
      begin
        nxt_cur.rdata = {20'h0, cur_ff.pc};
        nxt_cur.err = 1'b0;
      end
      else
      begin
        nxt_cur.rdata = 32'h0;
      end
    end
    // three nibble push, stack grows downward through ram
    if (cur_ff.push_cnt != 2'h0)
    begin
      nxt_cur.push_cnt = 2'(cur_ff.push_cnt - 2'h1);
      nxt_cur.sp = 9'(cur_ff.sp - 9'h1);
    end
    else if (push_stack)
    begin
      nxt_cur.push_cnt = 2'(memory_map_pkg::STACK_WORDS_PER_CALL);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_ff <= '0;
      cur_ff.sp <= 9'h1FF;
      cur_ff.pc <= {memory_map_pkg::RESET_PAGE, memory_map_pkg::RESET_STEP};
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  // page and step make a 12 bit address into 4096 words
  assign fetch_addr = cur_ff.pc;

  assign irq_request = |(cur_ff.ct_flags & cur_ff.ct_mask) |
                       |(cur_ff.sw_flags & cur_ff.sw_mask) |
                       (cur_ff.pt_flag & cur_ff.pt_mask) |
                       cur_ff.port_flag;

  assign pready = 1'b1;
  assign prdata = cur_ff.rdata;
  assign pslverr = psel && penable && cur_ff.err;

  property p_flag_read_clears;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && waddr_word == memory_map_pkg::CLOCK_TIMER_IRQ_FLAGS && ct_events == 4'h0)
      |=> (cur_ff.ct_flags == 4'h0);
  endproperty
  a_flag_read_clears: assert property (p_flag_read_clears) else $error("flag not cleared");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
      pt_event |=> cur_ff.pt_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      (cur_ff.pt_flag && cur_ff.pt_mask) |-> irq_request;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_unused_zero;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && waddr_word == memory_map_pkg::STOPWATCH_IRQ_FLAGS) |=> (prdata[3:2] == 2'h0);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

  property p_mask_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && waddr_word == memory_map_pkg::CLOCK_TIMER_IRQ_MASKS)
      |=> (cur_ff.ct_mask == $past(pwdata[3:0]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  property p_sw_mask_bits;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && waddr_word == memory_map_pkg::STOPWATCH_IRQ_MASKS) |=> (prdata[3:2] == 2'h0);
  endproperty
  a_sw_mask_bits: assert property (p_sw_mask_bits) else $error("ro bits set");

  property p_divider;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> (cur_ff.div_nibble == $past(divider_stages));
  endproperty
  a_divider: assert property (p_divider) else $error("divider stale");

  property p_push_len;
    @(posedge pclk) disable iff (!presetn)
      (push_stack && cur_ff.push_cnt == 2'h0)
      |=> (ram_we && ram_waddr == cur_ff.sp) [*3] ##1 (cur_ff.push_cnt == 2'h0);
  endproperty
  a_push_len: assert property (p_push_len) else $error("push length wrong");

  property p_ct_set_wins;
    @(posedge pclk) disable iff (!presetn)
      (ct_events != 4'h0)
      |=> ((cur_ff.ct_flags & $past(ct_events)) == $past(ct_events));
  endproperty
  a_ct_set_wins: assert property (p_ct_set_wins) else $error("clock timer event lost");

  property p_port_flag_set;
    @(posedge pclk) disable iff (!presetn)
      ((input_port_lines & ~cur_ff.port_prev & cur_ff.port_mask) != 4'h0)
      |=> cur_ff.port_flag;
  endproperty
  a_port_flag_set: assert property (p_port_flag_set) else $error("port flag not set");
endmodule // memory_map_irq_regs
`default_nettype wire

/* verification/cpu_model.sv */
// processor-side apb master model for the register bank
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  // one transfer, word index a, byte address 4a
  task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] d,
                      output logic [3:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {18'h0, a, 2'b00};
    pwdata <= {28'h0, d};
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[3:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show no stale value
    paddr <= ~{18'h0, a, 2'b00};
    pwdata <= ~{28'h0, d};
  endtask
endmodule // cpu_model
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench of the register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq_request, e;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb, memreg_data, q, v;
  logic [3:0] ct_events = 4'h0;
  logic [1:0] sw_events = 2'h0;
  logic pt_event = 1'b0;
  logic push_stack = 1'b0;
  logic [3:0] input_port_lines = 4'h0;
  logic [3:0] divider_stages = 4'h0;
  logic [3:0] memreg_pointer = 4'h0;
  logic [11:0] return_addr = 12'h0;
  logic [11:0] fetch_addr, r;
  logic [3:0] mem [16];
  logic [11:0] mreg [4] = '{12'hF10, 12'hF11, 12'hF12, 12'hF14};
  logic [3:0] mwr [4] = '{4'hF, 4'h3, 4'h1, 4'hF};
  logic [11:0] freg [4] = '{12'hF00, 12'hF01, 12'hF02, 12'hF04};
  logic [11:0] dtab [5] = '{12'h1FF, 12'hE00, 12'hE4F, 12'hE80, 12'hECF};
  int miscompares = 0;
  int samples_checked = 0;
  always #2.5 pclk = ~pclk;
  memory_map_irq_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ct_events(ct_events), .sw_events(sw_events),
    .pt_event(pt_event), .input_port_lines(input_port_lines),
    .divider_stages(divider_stages), .push_stack(push_stack), .return_addr(return_addr),
    .memreg_pointer(memreg_pointer), .memreg_data(memreg_data),
    .irq_request(irq_request), .fetch_addr(fetch_addr));
  cpu_model cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  task automatic chk_nib(input string n, input logic [3:0] ex, input logic [3:0] s);
    samples_checked++;
    if (s !== ex)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, ex, s);
    end
  endtask
  task automatic chk_bit(input string n, input logic ex, input logic s);
    samples_checked++;
    if (s !== ex)
    begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", n, ex, s);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [3:0] flag_of(input int i, input logic [3:0] s);
    return (i == 0) ? s : (i == 1) ? {2'b00, s[1:0]} : 4'h1;
  endfunction
  initial
  begin
    #100000;
    miscompares++;
    finish_test;
  end
  initial
  begin
    void'($urandom(32'h671A));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk_nib("fetch_page", 4'h1, fetch_addr[11:8]);
    chk_nib("fetch_step", 4'h0, fetch_addr[3:0] | fetch_addr[7:4]);
    for (int i = 0; i < 4; i++)
    begin
      cpu.xfer(1'b0, freg[i], 4'h0, q, e);
      chk_nib("flag_reset", 4'h0, q);
      cpu.xfer(1'b0, mreg[i], 4'h0, q, e);
      chk_nib("mask_reset", 4'h0, q);
      repeat (3)
      begin
        v = 4'($urandom);
        cpu.xfer(1'b1, mreg[i], v, q, e);
        cpu.xfer(1'b0, mreg[i], 4'h0, q, e);
        chk_nib("mask", v & mwr[i], q);
      end
      cpu.xfer(1'b1, mreg[i], 4'hF, q, e);
    end
    for (int i = 0; i < 4; i++)
    begin
      v = 4'($urandom) | 4'h1;
      @(posedge pclk);
      case (i)
        0: ct_events <= v;
        1: sw_events <= v[1:0];
        2: pt_event <= 1'b1;
        default: input_port_lines <= v;
      endcase
      @(posedge pclk);
      ct_events <= 4'h0;
      sw_events <= 2'h0;
      pt_event <= 1'b0;
      repeat (2) @(posedge pclk);
      chk_bit("irq_set", 1'b1, irq_request);
      cpu.xfer(1'b0, freg[i], 4'h0, q, e);
      chk_nib("flag", flag_of(i, v), q);
      cpu.xfer(1'b0, freg[i], 4'h0, q, e);
      chk_nib("flag_cleared", 4'h0, q);
      input_port_lines <= 4'h0;
      @(posedge pclk);
      chk_bit("irq_clear", 1'b0, irq_request);
    end
    cpu.xfer(1'b1, 12'hF10, 4'h0, q, e);
    @(posedge pclk);
    ct_events <= 4'hF;
    @(posedge pclk);
    ct_events <= 4'h0;
    repeat (2) @(posedge pclk);
    chk_bit("irq_masked", 1'b0, irq_request);
    cpu.xfer(1'b0, 12'hF00, 4'h0, q, e);
    chk_nib("flag_masked", 4'hF, q);
    fork
      cpu.xfer(1'b0, 12'hF02, 4'h0, q, e);
      begin
        @(posedge pclk);
        pt_event <= 1'b1;
        @(posedge pclk);
        pt_event <= 1'b0;
      end
    join
    chk_nib("flag_before_set", 4'h0, q);
    cpu.xfer(1'b0, 12'hF02, 4'h0, q, e);
    chk_nib("set_over_clear", 4'h1, q);
    repeat (4)
    begin
      v = 4'($urandom);
      divider_stages <= v;
      repeat (2) @(posedge pclk);
      cpu.xfer(1'b0, 12'hF20, 4'h0, q, e);
      chk_nib("divider", v, q);
    end
    for (int i = 0; i < 4; i++)
    begin
      r = (i[0]) ? 12'hF03 : 12'h200;
      cpu.xfer(i[1], r, 4'hF, q, e);
      chk_bit("slverr", 1'b1, e);
      if (!i[1]) chk_nib("unmapped", 4'h0, q);
    end
    for (int i = 0; i < 16; i++)
    begin
      mem[i] = 4'($urandom);
      cpu.xfer(1'b1, 12'(i), mem[i], q, e);
    end
    for (int i = 0; i < 16; i++)
    begin
      memreg_pointer <= 4'(i);
      repeat (2) @(posedge pclk);
      chk_nib("memreg", mem[i], memreg_data);
    end
    foreach (dtab[i])
    begin
      v = 4'($urandom);
      cpu.xfer(1'b1, dtab[i], v, q, e);
      cpu.xfer(1'b0, dtab[i], 4'h0, q, e);
      chk_nib("ram_word", v, q);
    end
    r = 12'($urandom);
    return_addr <= r;
    push_stack <= 1'b1;
    @(posedge pclk);
    push_stack <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      cpu.xfer(1'b0, 12'h1FF - 12'(i), 4'h0, q, e);
      chk_nib("stack", r[4*(2-i)+:4], q);
    end
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
